// ==== rtl/flash_cmd_consts.vh ====
`ifndef FLASH_CMD_CONSTS_VH
`define FLASH_CMD_CONSTS_VH
// first opcode byte of each command; the second byte is its complement
`define OP_WRITE_STATUS    8'h01
`define OP_READ_STATUS     8'h05
`define OP_WRITE_ENABLE    8'h06
`define OP_READ_SECURITY   8'h2B
`define OP_WRITE_SECURITY  8'h2F
`define OP_SET_BURST       8'hC0
`define OP_READ_FASTBOOT   8'h16
`define OP_WRITE_FASTBOOT  8'h17
`define OP_ERASE_FASTBOOT  8'h18
`define OP_ENTER_SECURE    8'hB1
`define OP_EXIT_SECURE     8'hC1
`define OP_WRITE_LOCK      8'h2C
`define OP_READ_LOCK       8'h2D
`define OP_PROG_SOLID      8'hE3
`define OP_ERASE_SOLID     8'hE4
`define OP_READ_SOLID      8'hE2
`define OP_WRITE_DYNAMIC   8'hE1
`define OP_READ_DYNAMIC    8'hE0
`define OP_READ_PASSCODE   8'h27
`define OP_WRITE_PASSCODE  8'h28
`define OP_PASSCODE_UNLOCK 8'h29
`define OP_RESET_ARM       8'h66
`define OP_RESET           8'h99
`define OP_PAGE_PROGRAM    8'h12
`define OP_SECTOR_ERASE    8'h21
`define OP_CHIP_ERASE      8'h60
// phase lengths in bytes or link clock cycles, then the config register address
`define ADDR_BYTES         4'h4
`define FIXED_DUMMY        5'h04
`define VAR_DUMMY          5'h14
`define PASS_DUMMY         5'h14
`define FASTBOOT_BYTES     4'h4
`define PASS_BYTES         4'h8
`define ONE_BYTE           4'h1
`define CONFIG_ADDR        8'h01
// status register layout
`define ST_BUSY            0
`define ST_WEL             1
`define ST_BP_LO           2
`define ST_BP_HI           5
// internal write cycle time, 2000 ns at the 8 ns core clock; sized for the timer
`define BUSY_CYCLES        16'h00FA
`endif

// ==== rtl/octal_flash_register_commands.v ====
// Function
// - write status: 01/FE, four address bytes, one data byte; address 01h hits config
// - read security: 2B/D4, four zero address bytes, four dummy, one byte out
// - write security: 2F/D0 opcode only
// - set burst length: C0/3F, four address bytes, one data byte in
// - read fast boot: 16/E9, four address, four dummy, one to four bytes out
// - write fast boot: 17/E8, four address bytes, exactly four data bytes
// - erase fast boot: 18/E7 opcode only
// - enter secure area B1/4E, leave C1/3E, opcode only
// - lock write 2C/D3 address plus one byte; lock read 2D/D2 four dummy
// - solid protect program E3/1C with address, erase E4/1B, read E2/1D
// - dynamic protect write E1/1E plus one byte; read E0/1F variable dummy
// - passcode read 27/D8 twenty dummy eight bytes; write 28/D7, unlock 29/D6
// - reset runs only when it directly follows reset arm; frames dropped as invalid in between do not disarm it
// - fixed-dummy register reads use four dummy cycles in both rates
// - marked reads return data at single rate even in double rate
// - status bit 0 is busy during program, erase or status write
// - write enable sets latch; status write, program and erase ignored without it; cleared on completion
// - program or erase to protected area ignored and clears latch
// - status bits 5..2 protect level, default zero, set by write status
// - chip erase only when all protect level bits are zero
// - read status: 05/FA, four address bytes, four dummy, one byte
// - write enable: 06/F9 opcode only
`timescale 1ns/1ps
`include "flash_cmd_consts.vh"
module octal_flash_register_commands
(
   input  wire        mclk,
   input  wire        rst_b,
   input  wire        sclk,
   input  wire        cs_b,
   input  wire        double_rate,
   input  wire [7:0]  dq_in,
   output reg  [7:0]  dq_out,
   output reg         dq_oe,
   output reg  [7:0]  flash_status
);
   localparam S_IDLE  = 7'b0000001;
   localparam S_OP    = 7'b0000010;
   localparam S_ADDR  = 7'b0000100;
   localparam S_DUMMY = 7'b0001000;
   localparam S_DIN   = 7'b0010000;
   localparam S_DOUT  = 7'b0100000;
   localparam S_WAIT  = 7'b1000000;
   localparam [15:0] BUSY_LOAD = `BUSY_CYCLES;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; first stages feed only second stages
   reg        sclk_s1, sclk_s2, sclk_d, cs_s1, cs_s2, cs_d, ddr_s1, ddr_s2;
   reg  [7:0] dq_s1, dq_s2;
   always @(posedge mclk)
   begin
      if (!rst_b)
      begin
         sclk_s1 <= 1'b0; sclk_s2 <= 1'b0; sclk_d <= 1'b0;
         cs_s1 <= 1'b1; cs_s2 <= 1'b1; cs_d <= 1'b1;
         ddr_s1 <= 1'b0; ddr_s2 <= 1'b0;
         dq_s1 <= 8'h00; dq_s2 <= 8'h00;
      end
      else
      begin
         sclk_s1 <= sclk; sclk_s2 <= sclk_s1; sclk_d <= sclk_s2;
         cs_s1 <= cs_b; cs_s2 <= cs_s1; cs_d <= cs_s2;
         ddr_s1 <= double_rate; ddr_s2 <= ddr_s1;
         dq_s1 <= dq_in; dq_s2 <= dq_s1;
      end
   end

   // edge strobes on the core clock
   wire sclk_rise = sclk_s2 & ~sclk_d;
   wire sclk_fall = ~sclk_s2 & sclk_d;
   wire cs_fall   = ~cs_s2 & cs_d;
   wire cs_rise   = cs_s2 & ~cs_d;
   wire in_edge   = ~cs_s2 & (sclk_rise | (ddr_s2 & sclk_fall));

   ////////////////////////////////////////////////////////////////////////
   // stored registers and command context
   reg  [6:0]  state;
   reg  [7:0]  op1, addr_lo, config_reg, security_reg, burst_reg, lock_reg;
   reg  [7:0]  solid_reg, dynamic_reg;
   reg  [31:0] fastboot_reg;
   reg  [63:0] passcode_reg, in_sr, out_sr;
   reg  [3:0]  protect_level, cnt, alen, dlen;
   reg  [4:0]  dcnt, dum;
   reg         busy, write_enable_latch, reset_armed, secure_area, single_out, valid;
   reg  [15:0] busy_cnt;

   // opcode lookup: address, dummy and data lengths per command
   reg  [3:0] next_alen, next_dlen;
   reg  [4:0] next_dum;
   reg        next_known, next_single;
   always @*
   begin
      next_alen = 4'h0; next_dlen = 4'h0; next_dum = 5'h00;
      next_known = 1'b1; next_single = 1'b0;
      case (op1)
         `OP_WRITE_STATUS, `OP_SET_BURST, `OP_WRITE_LOCK, `OP_WRITE_DYNAMIC:
         begin
            next_alen = `ADDR_BYTES; next_dlen = `ONE_BYTE;
         end
         `OP_READ_STATUS, `OP_READ_SECURITY, `OP_READ_LOCK:
         begin
            next_alen = `ADDR_BYTES; next_dum = `FIXED_DUMMY;
         end
         `OP_READ_FASTBOOT:
         begin
            next_alen = `ADDR_BYTES; next_dum = `FIXED_DUMMY;
            next_single = 1'b1;
         end
         `OP_WRITE_FASTBOOT:
         begin
            next_alen = `ADDR_BYTES; next_dlen = `FASTBOOT_BYTES;
         end
         `OP_PROG_SOLID, `OP_PAGE_PROGRAM, `OP_SECTOR_ERASE:
            next_alen = `ADDR_BYTES;
         `OP_READ_SOLID, `OP_READ_DYNAMIC:
         begin
            next_alen = `ADDR_BYTES; next_dum = `VAR_DUMMY;
         end
         `OP_READ_PASSCODE:
         begin
            next_alen = `ADDR_BYTES; next_dum = `PASS_DUMMY;
         end
         `OP_WRITE_PASSCODE, `OP_PASSCODE_UNLOCK:
         begin
            next_alen = `ADDR_BYTES; next_dlen = `PASS_BYTES;
         end
         `OP_WRITE_ENABLE, `OP_WRITE_SECURITY, `OP_ERASE_FASTBOOT,
         `OP_ENTER_SECURE, `OP_EXIT_SECURE, `OP_ERASE_SOLID,
         `OP_RESET_ARM, `OP_RESET, `OP_CHIP_ERASE:
            next_known = 1'b1; // opcode only
         default:
            next_known = 1'b0; // undefined opcodes are dropped
      endcase
   end

   // read data image, most significant byte leaves first
   reg [63:0] next_out;
   always @*
   begin
      case (op1)
         `OP_READ_STATUS:   next_out = {flash_status, 56'h0};
         `OP_READ_SECURITY: next_out = {security_reg, 56'h0};
         `OP_READ_FASTBOOT: next_out = {fastboot_reg, 32'h0};
         `OP_READ_LOCK:     next_out = {lock_reg, 56'h0};
         `OP_READ_SOLID:    next_out = {solid_reg, 56'h0};
         `OP_READ_DYNAMIC:  next_out = {dynamic_reg, 56'h0};
         `OP_READ_PASSCODE: next_out = passcode_reg;
         default:           next_out = 64'h0;
      endcase
   end

   // writes that move the array or status need the latch and an idle device
   wire wr_ok    = write_enable_latch & ~busy;
   wire full_din = (cnt == dlen);
   wire prot_any = |protect_level;
   wire out_edge = sclk_fall | (ddr_s2 & ~single_out & sclk_rise);

   ////////////////////////////////////////////////////////////////////////
   // link sequencer and command execution at chip select release
   always @(posedge mclk)
   begin
      if (!rst_b)
      begin
         state <= S_IDLE; op1 <= 8'h00; addr_lo <= 8'h00; cnt <= 4'h0;
         alen <= 4'h0; dlen <= 4'h0; dum <= 5'h00; dcnt <= 5'h00;
         in_sr <= 64'h0; out_sr <= 64'h0; valid <= 1'b0; single_out <= 1'b0;
         dq_out <= 8'h00; dq_oe <= 1'b0;
         config_reg <= 8'h00; security_reg <= 8'h00; burst_reg <= 8'h00;
         lock_reg <= 8'h00; solid_reg <= 8'h00; dynamic_reg <= 8'h00;
         fastboot_reg <= 32'hFFFF_FFFF; passcode_reg <= 64'hFFFF_FFFF_FFFF_FFFF;
         protect_level <= 4'h0; busy <= 1'b0; write_enable_latch <= 1'b0; busy_cnt <= 16'h0;
         reset_armed <= 1'b0; secure_area <= 1'b0;
      end
      else
      begin
         // internal write cycle timer
         if (busy_cnt != 16'h0)
         begin
            busy_cnt <= busy_cnt - 16'h1;
            if (busy_cnt == 16'h1)
            begin
               busy <= 1'b0;
               write_enable_latch <= 1'b0;
            end
         end
         if (cs_fall)
         begin
            state <= S_OP; cnt <= 4'h0; valid <= 1'b0; dq_oe <= 1'b0;
         end
         else if (cs_rise)
         begin
            state <= S_IDLE; dq_oe <= 1'b0;
            if (valid)
            begin
               reset_armed <= (op1 == `OP_RESET_ARM);
               case (op1)
                  `OP_WRITE_ENABLE: write_enable_latch <= 1'b1;
                  `OP_WRITE_STATUS:
                     if (wr_ok && full_din && state == S_DIN)
                     begin
                        if (addr_lo == `CONFIG_ADDR)
                           config_reg <= in_sr[7:0];
                        else
                           protect_level <= in_sr[`ST_BP_HI:`ST_BP_LO];
                        busy <= 1'b1; busy_cnt <= BUSY_LOAD;
                     end
                  `OP_PAGE_PROGRAM, `OP_SECTOR_ERASE, `OP_CHIP_ERASE:
                     if (wr_ok)
                     begin
                        if (prot_any)
                           write_enable_latch <= 1'b0;
                        else
                        begin
                           busy <= 1'b1; busy_cnt <= BUSY_LOAD;
                        end
                     end
                  `OP_WRITE_SECURITY: security_reg[1] <= 1'b1;
                  `OP_SET_BURST: if (full_din) burst_reg <= in_sr[7:0];
                  `OP_WRITE_FASTBOOT: if (full_din) fastboot_reg <= in_sr[31:0];
                  `OP_ERASE_FASTBOOT: fastboot_reg <= 32'hFFFF_FFFF;
                  `OP_ENTER_SECURE: secure_area <= 1'b1;
                  `OP_EXIT_SECURE: secure_area <= 1'b0;
                  `OP_WRITE_LOCK: if (full_din) lock_reg <= in_sr[7:0];
                  `OP_PROG_SOLID: solid_reg <= 8'hFF;
                  `OP_ERASE_SOLID: solid_reg <= 8'h00;
                  `OP_WRITE_DYNAMIC: if (full_din) dynamic_reg <= in_sr[7:0];
                  `OP_WRITE_PASSCODE: if (full_din) passcode_reg <= in_sr;
                  `OP_RESET:
                     if (reset_armed)
                     begin
                        write_enable_latch <= 1'b0; busy <= 1'b0; busy_cnt <= 16'h0;
                        secure_area <= 1'b0; config_reg <= 8'h00;
                     end
                  default: ;
               endcase
            end
         end
         else
         begin
            case (state)
               S_OP:
                  if (in_edge)
                  begin
                     cnt <= cnt + 4'h1;
                     if (cnt == 4'h0)
                        op1 <= dq_s2;
                     else if (dq_s2 != ~op1 || !next_known)
                        state <= S_WAIT;
                     else
                     begin
                        valid <= 1'b1; cnt <= 4'h0;
                        alen <= next_alen; dlen <= next_dlen; dum <= next_dum;
                        single_out <= next_single; dcnt <= 5'h00;
                        state <= (next_alen != 4'h0) ? S_ADDR : S_WAIT;
                     end
                  end
               S_ADDR:
                  if (in_edge)
                  begin
                     addr_lo <= dq_s2; cnt <= cnt + 4'h1;
                     if (cnt == alen - 4'h1)
                     begin
                        cnt <= 4'h0;
                        if (dum != 5'h00)
                           state <= S_DUMMY;
                        else if (dlen != 4'h0)
                           state <= S_DIN;
                        else
                           state <= S_WAIT;
                     end
                  end
               S_DUMMY:
                  // dummy counted in link clock cycles, either rate
                  if (sclk_rise)
                  begin
                     dcnt <= dcnt + 5'h01;
                     if (dcnt == dum - 5'h01)
                     begin
                        out_sr <= next_out; state <= S_DOUT;
                     end
                  end
               S_DIN:
                  if (in_edge && cnt != `PASS_BYTES)
                  begin
                     in_sr <= {in_sr[55:0], dq_s2}; cnt <= cnt + 4'h1;
                  end
               S_DOUT:
                  // bytes past the image read as zero
                  if (out_edge)
                  begin
                     dq_oe <= 1'b1; dq_out <= out_sr[63:56];
                     out_sr <= {out_sr[55:0], 8'h00};
                  end
               S_IDLE, S_WAIT: ;
               default: state <= S_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // visible status byte, top two bits fixed at zero
   always @(posedge mclk)
   begin
      if (!rst_b)
         flash_status <= 8'h00;
      else
         flash_status <= {2'b00, protect_level, write_enable_latch, busy};
   end
endmodule // octal_flash_register_commands

// ==== bench/flash_host_model.sv ====
`timescale 1ns/1ps
module flash_host_model
(
   input  wire       mclk,
   output reg        sclk,
   output reg        cs_b,
   output reg  [7:0] dq_in,
   input  wire [7:0] dq_out,
   input  wire       dq_oe
);
   //////////////////////////////////////////////////////////////////////////////////
   // link clock stands still low between frames
   initial
   begin
      sclk  = 1'b0;
      cs_b  = 1'b1;
      dq_in = 8'h5a;
   end

   // one link cycle of 10 mclk; byte held across the rise
   task send(input [7:0] b);
   begin
      dq_in <= b;
      repeat (5) @(posedge mclk);
      sclk <= 1'b1;
      repeat (5) @(posedge mclk);
      sclk <= 1'b0;
   end
   endtask

   // whole frame: opcode pair, address, write bytes msb first, dummy, read bytes
   task xfer(input [15:0] opc, input integer na, input [7:0] a4, input integer nw,
             input [63:0] wd, input integer nd, input integer nr, output [63:0] rd);
      integer i;
   begin
      rd = 64'h0000_0000_0000_0000;
      @(posedge mclk);
      cs_b <= 1'b0;
      send(opc[15:8]);
      send(opc[7:0]);
      for (i = 0; i < na; i = i + 1)
         send((i == na - 1) ? a4 : 8'h00);
      for (i = nw - 1; i >= 0; i = i - 1)
         send(wd[8*i +: 8]);
      // dummy lines are not meaningful, so they toggle every cycle
      for (i = 0; i < nd; i = i + 1)
         send(~dq_in);
      for (i = 0; i < nr; i = i + 1)
      begin
         repeat (5) @(posedge mclk);
         rd = {rd[55:0], dq_out};
         dq_in <= ~dq_in;
         sclk <= 1'b1;
         repeat (5) @(posedge mclk);
         sclk <= 1'b0;
      end
      repeat (5) @(posedge mclk);
      cs_b <= 1'b1;
      dq_in <= ~dq_in;
      repeat (6) @(posedge mclk);
   end
   endtask

   // double rate frame: a byte on every link edge, zero address, dummy in full cycles
   task xfer_ddr(input [7:0] op, input integer nd, input integer nr, output [63:0] rd);
      integer i;
   begin
      rd = 64'h0000_0000_0000_0000;
      @(posedge mclk);
      cs_b <= 1'b0;
      // data settles three mclk before each edge, held two after it
      for (i = 0; i < 6 + 2 * nd; i = i + 1)
      begin
         dq_in <= (i == 0) ? op : (i == 1) ? ~op : 8'h00;
         repeat (3) @(posedge mclk);
         sclk <= ~sclk;
         repeat (2) @(posedge mclk);
      end
      for (i = 0; i < nr; i = i + 1)
      begin
         repeat (5) @(posedge mclk);
         rd = {rd[55:0], dq_out};
         sclk <= ~sclk;
      end
      repeat (5) @(posedge mclk);
      cs_b <= 1'b1;
      // park the clock low only once the frame is closed
      repeat (5) @(posedge mclk);
      sclk <= 1'b0;
      repeat (6) @(posedge mclk);
   end
   endtask
endmodule // flash_host_model

// ==== bench/octal_flash_register_commands_properties.sv ====
`timescale 1ns/1ps
module flash_reg_checker
(
   input  wire       mclk,
   input  wire       rst_b,
   input  wire       cs_b,
   input  wire       dq_oe,
   input  wire [7:0] flash_status
);
   reg [8:0] busy_cnt;

   //////////////////////////////////////////////////////////////////////////////////
   // length of the current busy stretch, cleared when idle
   always @(posedge mclk)
   begin
      if (!rst_b)
         busy_cnt <= 9'h000;
      else if (flash_status[0])
         busy_cnt <= busy_cnt + 9'h001;
      else
         busy_cnt <= 9'h000;
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   //////////////////////////////////////////////////////////////////////////////////
   chk_rsvd_zero: assert property (flash_status[7:6] == 2'b00)
      else $error("reserved status bits not zero");
   chk_busy_hold: assert property ($rose(flash_status[0]) |=> flash_status[0] [*8])
      else $error("busy dropped early");
   // allow one cycle either side for the edge that starts the cycle
   chk_busy_length: assert property ($fell(flash_status[0]) |-> (busy_cnt >= 9'h0F9) && (busy_cnt <= 9'h0FB))
      else $error("busy stretch not 250 cycles");
   chk_wel_at_end: assert property ($fell(flash_status[0]) |-> !flash_status[1])
      else $error("latch still set after write cycle");
   chk_busy_needs_wel: assert property ($rose(flash_status[0]) |-> $past(flash_status[1]))
      else $error("write cycle started without latch");
   chk_level_in_write: assert property (!$stable(flash_status[5:2]) |-> flash_status[0])
      else $error("protect level changed outside write");
   chk_oe_release: assert property ($rose(cs_b) |-> ##[1:6] !dq_oe)
      else $error("output drive not released");
   chk_oe_in_frame: assert property ($rose(dq_oe) |-> !cs_b)
      else $error("output drive outside frame");
endmodule // flash_reg_checker

bind octal_flash_register_commands flash_reg_checker u_chk
(
   .mclk         (mclk),
   .rst_b        (rst_b),
   .cs_b         (cs_b),
   .dq_oe        (dq_oe),
   .flash_status (flash_status)
);

// ==== bench/test_octal_flash_register_commands.sv ====
`timescale 1ns/1ps
`include "flash_cmd_consts.vh"
module test_octal_flash_register_commands;
   reg         mclk;
   reg         rst_b;
   reg         double_rate;
   wire        sclk;
   wire        cs_b;
   wire [7:0]  dq_in;
   wire [7:0]  dq_out;
   wire        dq_oe;
   wire [7:0]  flash_status;
   reg  [63:0] rd;
   integer     mismatches;
   integer     num_checks;

   octal_flash_register_commands u_dut (.mclk(mclk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b),
      .double_rate(double_rate), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
      .flash_status(flash_status));
   flash_host_model u_host (.mclk(mclk), .sclk(sclk), .cs_b(cs_b), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe(dq_oe));

   //////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task wrap_up;
   begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   end
   endtask

   task check(input string name, input [63:0] exp, input [63:0] got);
   begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
         mismatches = mismatches + 1;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   end
   endtask

   // well formed command: second opcode byte is the complement
   task cmd(input [7:0] op, input integer na, input integer nw, input [63:0] wd,
            input integer nd, input integer nr);
   begin
      u_host.xfer({op, ~op}, na, 8'h00, nw, wd, nd, nr, rd);
   end
   endtask

   // bounded wait for the write cycle to finish
   task wait_idle;
      integer i;
   begin
      for (i = 0; i < 400 && flash_status[0] !== 1'b0; i = i + 1)
         @(posedge mclk);
   end
   endtask

   //////////////////////////////////////////////////////////////////////////////////
   // watchdog: the sequence needs about 5000 cycles
   initial
   begin
      repeat (60000) @(posedge mclk);
      mismatches = mismatches + 1;
      wrap_up;
   end

   initial
   begin
      mismatches  = 0;
      num_checks  = 0;
      rst_b       = 1'b0;
      double_rate = 1'b0;
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (6) @(posedge mclk);
      check("status_rst", 8'h00, flash_status);
      cmd(`OP_READ_STATUS, 4, 0, 0, 4, 1);
      check("read_status_cmd_rst", 8'h00, rd);
      cmd(`OP_WRITE_STATUS, 4, 1, 8'hFF, 0, 0);
      check("write_status_cmd_nowel", 8'h00, flash_status);
      u_host.xfer({`OP_WRITE_ENABLE, 8'hF8}, 0, 8'h00, 0, 0, 0, 0, rd);
      check("write_enable_cmd_badpair", 8'h00, flash_status);
      cmd(`OP_WRITE_ENABLE, 0, 0, 0, 0, 0);
      check("write_enable_cmd", 8'h02, flash_status);
      cmd(`OP_WRITE_STATUS, 4, 1, 8'hFF, 0, 0);
      check("write_status_cmd_busy", 8'h3F, flash_status);
      cmd(`OP_READ_STATUS, 4, 0, 0, 4, 1);
      check("read_status_cmd_busy", 8'h3F, rd);
      wait_idle;
      check("write_status_cmd_done", 8'h3C, flash_status);
      cmd(`OP_WRITE_ENABLE, 0, 0, 0, 0, 0);
      cmd(`OP_CHIP_ERASE, 0, 0, 0, 0, 0);
      check("ce_prot", 8'h3C, flash_status);
      cmd(`OP_WRITE_ENABLE, 0, 0, 0, 0, 0);
      cmd(`OP_SECTOR_ERASE, 4, 0, 0, 0, 0);
      check("se_prot", 8'h3C, flash_status);
      cmd(`OP_WRITE_ENABLE, 0, 0, 0, 0, 0);
      cmd(`OP_WRITE_STATUS, 4, 1, 8'h00, 0, 0);
      wait_idle;
      check("unprotect", 8'h00, flash_status);
      cmd(`OP_WRITE_ENABLE, 0, 0, 0, 0, 0);
      cmd(`OP_CHIP_ERASE, 0, 0, 0, 0, 0);
      check("ce_run", 8'h03, flash_status);
      wait_idle;
      check("ce_done", 8'h00, flash_status);
      cmd(`OP_READ_FASTBOOT, 4, 0, 0, 4, 4);
      check("fbr_rst", 64'hFFFF_FFFF, rd);
      cmd(`OP_WRITE_FASTBOOT, 4, 4, 64'h1234_5678, 0, 0);
      cmd(`OP_READ_FASTBOOT, 4, 0, 0, 4, 4);
      check("fbr_wr", 64'h1234_5678, rd);
      cmd(`OP_READ_FASTBOOT, 4, 0, 0, 4, 1);
      check("fbr_one", 8'h12, rd);
      double_rate <= 1'b1;
      u_host.xfer_ddr(`OP_READ_FASTBOOT, 4, 4, rd);
      check("fbr_ddr", 64'h1212_3434, rd);
      double_rate <= 1'b0;
      cmd(`OP_ERASE_FASTBOOT, 0, 0, 0, 0, 0);
      cmd(`OP_READ_FASTBOOT, 4, 0, 0, 4, 4);
      check("fbr_erase", 64'hFFFF_FFFF, rd);
      cmd(`OP_READ_PASSCODE, 4, 0, 0, 20, 8);
      check("pass_rst", 64'hFFFF_FFFF_FFFF_FFFF, rd);
      cmd(`OP_WRITE_PASSCODE, 4, 8, 64'h0102_0304_0506_0708, 0, 0);
      cmd(`OP_READ_PASSCODE, 4, 0, 0, 20, 8);
      check("pass_wr", 64'h0102_0304_0506_0708, rd);
      cmd(`OP_READ_LOCK, 4, 0, 0, 4, 1);
      check("lock_rst", 8'h00, rd);
      cmd(`OP_WRITE_LOCK, 4, 1, 8'hA5, 0, 0);
      double_rate <= 1'b1;
      u_host.xfer_ddr(`OP_READ_LOCK, 4, 2, rd);
      check("lock_ddr", 16'hA500, rd);
      double_rate <= 1'b0;
      cmd(`OP_WRITE_DYNAMIC, 4, 1, 8'h5A, 0, 0);
      cmd(`OP_READ_DYNAMIC, 4, 0, 0, 20, 1);
      check("dyn_wr", 8'h5A, rd);
      cmd(`OP_WRITE_SECURITY, 0, 0, 0, 0, 0);
      cmd(`OP_READ_SECURITY, 4, 0, 0, 4, 1);
      check("secur_wr", 8'h02, rd);
      cmd(`OP_PROG_SOLID, 4, 0, 0, 0, 0);
      cmd(`OP_READ_SOLID, 4, 0, 0, 20, 1);
      check("solid_prog", 8'hFF, rd);
      cmd(`OP_ERASE_SOLID, 0, 0, 0, 0, 0);
      cmd(`OP_READ_SOLID, 4, 0, 0, 20, 1);
      check("solid_erase", 8'h00, rd);
      cmd(`OP_RESET_ARM, 0, 0, 0, 0, 0);
      cmd(`OP_WRITE_ENABLE, 0, 0, 0, 0, 0);
      cmd(`OP_RESET, 0, 0, 0, 0, 0);
      check("rst_disarmed", 8'h02, flash_status);
      cmd(`OP_RESET_ARM, 0, 0, 0, 0, 0);
      cmd(`OP_RESET, 0, 0, 0, 0, 0);
      check("rst_armed", 8'h00, flash_status);
      cmd(`OP_READ_STATUS, 4, 0, 0, 4, 1);
      check("read_status_cmd_end", 8'h00, rd);
      wrap_up;
   end
endmodule // test_octal_flash_register_commands
